// ### design/cgc_consts.vh
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH
// ****************************************
// Register offsets
// ****************************************
`define CGC_ADDR_MOR 8'h00
`define CGC_ADDR_MCFR 8'h04
`define CGC_ADDR_PLLR 8'h08
`define CGC_ADDR_SR 8'h0C
`define CGC_ADDR_IER 8'h10
`define CGC_ADDR_IDR 8'h14
`define CGC_ADDR_IMR 8'h18
// ****************************************
// Field positions and widths
// ****************************************
`define CGC_MOR_EN 0
`define CGC_MOR_BYP 1
`define CGC_MOR_CNT_LO 8
`define CGC_MOR_CNT_HI 15
`define CGC_MCFR_TALLY_HI 15
`define CGC_MCFR_RDY 16
`define CGC_PLLR_DIV_HI 7
`define CGC_PLLR_CNT_LO 8
`define CGC_PLLR_CNT_HI 13
`define CGC_PLLR_GAIN_LO 16
`define CGC_PLLR_GAIN_HI 26
`define CGC_SR_STABLE 0
`define CGC_SR_LOCK 2
`define CGC_SR_FRDY 3
`define CGC_OSC_PRESCALE 3'h7
`define CGC_FREQ_PERIODS 5'h10
`define CGC_RESP_OKAY 2'h0
`define CGC_RESP_SLVERR 2'h2
`endif

// ### design/cgc_sync2.v
// ****************************************
// Two flip-flop level synchroniser
// ****************************************
module cgc_sync2 (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Level in and out.
    input wire din,
    output wire dout
);
    reg stage1_reg;
    reg stage2_reg;

    // The first stage feeds only the second one.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end else begin
            stage1_reg <= din;
            stage2_reg <= stage1_reg;
        end
    end

    assign dout = stage2_reg;
endmodule

// ### design/cgc_edge.v
// ****************************************
// Synchronised clock edge detector
// ****************************************
module cgc_edge (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Foreign clock in.
    input wire clk_in,
    // Edge pulses, one ref_clk cycle each.
    output wire rise,
    output wire fall
);
    wire level;
    reg last_reg;

    cgc_sync2 u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(clk_in),
        .dout(level)
    );

    // Remembers the previous synchronised level.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= level;
        end
    end

    assign rise = level & ~last_reg;
    assign fall = ~level & last_reg;
endmodule

// ### design/cgc_top.v
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`include "cgc_consts.vh"
// ****************************************
// Clock generator control with AXI4-Lite registers
// ****************************************
module cgc_top (
    // Clock and reset.
    input wire ref_clk,
    input wire rst,
    // Clocks from the analog macros.
    input wire slow_clock,
    input wire main_osc_clk,
    input wire pll_core_clk,
    // Analog control.
    output reg main_osc_power,
    output reg osc_bypass_out,
    output reg pll_power,
    output reg [7:0] pll_div_out,
    output reg [10:0] pll_gain_out,
    output wire main_clock_out,
    output wire pll_clock_out,
    output wire source_is_slow,
    output wire irq,
    // AXI4-Lite write address.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data.
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address.
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data.
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Register state.
    reg en_reg;
    reg byp_reg;
    reg [7:0] osc_cnt_reg;
    reg [7:0] div_reg;
    reg [10:0] gain_reg;
    reg [5:0] pll_cnt_reg;
    reg [2:0] mask_reg;
    reg stable_reg;
    reg lock_reg;
    reg frdy_reg;
    // Counters.
    reg [7:0] osc_down_reg;
    reg [2:0] osc_pre_reg;
    reg osc_run_reg;
    reg [5:0] pll_down_reg;
    reg pll_run_reg;
    reg [15:0] tally_reg;
    reg [4:0] fall_cnt_reg;
    reg [1:0] fstate_reg;
    // Bus capture.
    reg [7:0] awaddr_reg;
    reg aw_full_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;
    reg w_full_reg;

    localparam F_IDLE = 2'h0;
    localparam F_WAIT = 2'h1;
    localparam F_COUNT = 2'h2;
    localparam F_DONE = 2'h3;

    wire slow_rise;
    wire slow_fall;
    wire main_rise;

    // Slow and main clocks are foreign; sample them through two flops.
    cgc_edge u_slow (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_in(slow_clock),
        .rise(slow_rise),
        .fall(slow_fall)
    );
    cgc_edge u_main (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_in(main_osc_clk),
        .rise(main_rise),
        .fall()
    );

    // Merges a written word with byte strobes.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Write channel handshakes: hold each until both are captured.
    assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire wr_go = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    wire rd_go = s_axi_arvalid & s_axi_arready;
    wire [31:0] mor_word = merge({16'h0000, osc_cnt_reg, 6'h00, byp_reg, en_reg},
                                  wdata_reg, wstrb_reg);
    wire [31:0] pllr_word = merge({5'h00, gain_reg, 2'h0, pll_cnt_reg, div_reg},
                                   wdata_reg, wstrb_reg);
    wire wr_mor = wr_go && (awaddr_reg == `CGC_ADDR_MOR);
    wire wr_pllr = wr_go && (awaddr_reg == `CGC_ADDR_PLLR);
    wire wr_ier = wr_go && (awaddr_reg == `CGC_ADDR_IER);
    wire wr_idr = wr_go && (awaddr_reg == `CGC_ADDR_IDR);
    wire new_en = mor_word[`CGC_MOR_EN];
    wire [7:0] new_div = pllr_word[`CGC_PLLR_DIV_HI:0];
    wire [10:0] new_gain = pllr_word[`CGC_PLLR_GAIN_HI:`CGC_PLLR_GAIN_LO];
    wire [5:0] new_pcnt = pllr_word[`CGC_PLLR_CNT_HI:`CGC_PLLR_CNT_LO];
    wire pll_change = wr_pllr && (new_gain != 11'h000) &&
                      ((gain_reg == 11'h000) || (new_gain != gain_reg) || (new_div != div_reg));
    wire osc_start = wr_mor & new_en;

    // Capture of address and data, taken in either order.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CGC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_mor | wr_pllr | wr_ier | wr_idr) ?
                               `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en_reg <= 1'b0;
            byp_reg <= 1'b0;
            osc_cnt_reg <= 8'h00;
            div_reg <= 8'h00;
            gain_reg <= 11'h000;
            pll_cnt_reg <= 6'h00;
            mask_reg <= 3'h0;
        end else begin
            if (wr_mor) begin
                en_reg <= new_en;
                byp_reg <= mor_word[`CGC_MOR_BYP];
                osc_cnt_reg <= mor_word[`CGC_MOR_CNT_HI:`CGC_MOR_CNT_LO];
            end
            if (wr_pllr) begin
                div_reg <= new_div;
                gain_reg <= new_gain;
                pll_cnt_reg <= new_pcnt;
            end
            if (wr_ier) begin
                mask_reg <= mask_reg | {wdata_reg[`CGC_SR_FRDY],
                                        wdata_reg[`CGC_SR_LOCK], wdata_reg[`CGC_SR_STABLE]};
            end else if (wr_idr) begin
                mask_reg <= mask_reg & ~{wdata_reg[`CGC_SR_FRDY],
                                         wdata_reg[`CGC_SR_LOCK], wdata_reg[`CGC_SR_STABLE]};
            end
        end
    end

    // Oscillator start-up counter, ticking every eight slow cycles.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_run_reg <= 1'b0;
            osc_down_reg <= 8'h00;
            osc_pre_reg <= 3'h0;
            stable_reg <= 1'b0;
        end else if (wr_mor & ~new_en) begin
            osc_run_reg <= 1'b0;
            stable_reg <= 1'b0;
        end else if (osc_start) begin
            stable_reg <= 1'b0;
            osc_run_reg <= 1'b1;
            osc_down_reg <= mor_word[`CGC_MOR_CNT_HI:`CGC_MOR_CNT_LO];
            osc_pre_reg <= `CGC_OSC_PRESCALE;
        end else if (osc_run_reg) begin
            if (osc_down_reg == 8'h00) begin
                osc_run_reg <= 1'b0;
                stable_reg <= 1'b1;
            end else if (slow_rise) begin
                osc_pre_reg <= osc_pre_reg - 3'h1;
                if (osc_pre_reg == 3'h0) begin
                    osc_pre_reg <= `CGC_OSC_PRESCALE;
                    osc_down_reg <= osc_down_reg - 8'h01;
                end
            end
        end
    end

    // Main-clock frequency measurement from a slow rising edge to the sixteenth slow falling edge.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fstate_reg <= F_IDLE;
            tally_reg <= 16'h0000;
            fall_cnt_reg <= 5'h00;
            frdy_reg <= 1'b0;
        end else if (~stable_reg) begin
            fstate_reg <= F_IDLE;
            frdy_reg <= 1'b0;
        end else begin
            case (fstate_reg)
                F_IDLE: begin
                    tally_reg <= 16'h0000;
                    fall_cnt_reg <= 5'h00;
                    fstate_reg <= F_WAIT;
                end
                F_WAIT: begin
                    if (slow_rise) begin
                        fstate_reg <= F_COUNT;
                    end
                end
                F_COUNT: begin
                    if (main_rise) begin
                        tally_reg <= tally_reg + 16'h0001;
                    end
                    if (slow_fall) begin
                        fall_cnt_reg <= fall_cnt_reg + 5'h01;
                        if (fall_cnt_reg + 5'h01 == `CGC_FREQ_PERIODS) begin
                            fstate_reg <= F_DONE;
                            frdy_reg <= 1'b1;
                        end
                    end
                end
                F_DONE: begin
                    fstate_reg <= F_DONE;
                end
                default: begin
                    fstate_reg <= F_IDLE;
                end
            endcase
        end
    end

    // PLL settle counter, one decrement per slow cycle.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pll_run_reg <= 1'b0;
            pll_down_reg <= 6'h00;
            lock_reg <= 1'b0;
        end else if (wr_pllr & (new_gain == 11'h000)) begin
            pll_run_reg <= 1'b0;
            lock_reg <= 1'b0;
        end else if (pll_change) begin
            lock_reg <= 1'b0;
            pll_run_reg <= 1'b1;
            pll_down_reg <= new_pcnt;
        end else if (pll_run_reg) begin
            if (pll_down_reg == 6'h00) begin
                pll_run_reg <= 1'b0;
                lock_reg <= 1'b1;
            end else if (slow_rise) begin
                pll_down_reg <= pll_down_reg - 6'h01;
            end
        end
    end

    // Analog controls registered from the configuration.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            main_osc_power <= 1'b0;
            osc_bypass_out <= 1'b0;
            pll_power <= 1'b0;
            pll_div_out <= 8'h00;
            pll_gain_out <= 11'h000;
        end else begin
            main_osc_power <= en_reg;
            osc_bypass_out <= byp_reg;
            pll_power <= (gain_reg != 11'h000);
            pll_div_out <= div_reg;
            pll_gain_out <= gain_reg;
        end
    end

    // Clock outputs: gated so a stopped source shows low.
    assign main_clock_out = (main_osc_power | osc_bypass_out) & main_osc_clk;
    assign pll_clock_out = pll_power & (pll_div_out != 8'h00) & pll_core_clk;
    assign source_is_slow = 1'b1;
    assign irq = |(mask_reg & {frdy_reg, lock_reg, stable_reg});

    // Read channel.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CGC_RESP_OKAY;
        end else if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `CGC_RESP_OKAY;
            case (s_axi_araddr)
                `CGC_ADDR_MOR: s_axi_rdata <= {16'h0000, osc_cnt_reg, 6'h00, byp_reg, en_reg};
                `CGC_ADDR_MCFR: s_axi_rdata <= {15'h0000, frdy_reg, tally_reg};
                `CGC_ADDR_PLLR: s_axi_rdata <= {5'h00, gain_reg, 2'h0, pll_cnt_reg, div_reg};
                `CGC_ADDR_SR: s_axi_rdata <= {28'h0000000, frdy_reg, lock_reg, 1'b0, stable_reg};
                `CGC_ADDR_IMR: s_axi_rdata <= {28'h0000000, mask_reg[2:1], 1'b0, mask_reg[0]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `CGC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ### sim/cgc_top_assertions.sv
`include "cgc_consts.vh"
// ********
// Port checker for the clock generator control block
// ********
module cgc_chk (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Analog control.
    input wire logic main_osc_power,
    input wire logic osc_bypass_out,
    input wire logic pll_power,
    input wire logic [7:0] pll_div_out,
    input wire logic [10:0] pll_gain_out,
    input wire logic main_clock_out,
    input wire logic pll_clock_out,
    input wire logic source_is_slow,
    // Register bus.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;

    // All checks share the one system clock and its reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_slow_selected: assert property (source_is_slow)
        else $error("slow clock not selected");
    a_div_zero_low: assert property (pll_div_out == 8'h00 |-> !pll_clock_out)
        else $error("pll clock active with zero prescale");
    a_gain_zero_off: assert property ((pll_gain_out == 11'h000) [*2] |-> !pll_power)
        else $error("pll powered with zero gain");
    a_pll_dark: assert property (!pll_power |-> !pll_clock_out)
        else $error("pll clock active while unpowered");
    a_main_dark: assert property (!main_osc_power && !osc_bypass_out
        |-> !main_clock_out)
        else $error("main clock active while off");
    // Both channels are captured first; the response is launched on the next edge.
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_readonly_err: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_awaddr == `CGC_ADDR_MCFR |-> ##2 s_axi_bresp == `CGC_RESP_SLVERR)
        else $error("read-only write not refused");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read data dropped");

    c_pll_on: cover property ($rose(pll_power));
    c_bus_err: cover property (s_axi_bvalid && s_axi_bresp == `CGC_RESP_SLVERR);
    c_bypass: cover property (osc_bypass_out && $rose(main_clock_out));
endmodule

bind cgc_top cgc_chk i_chk (.*);

// ### sim/cgc_osc_model.sv
// ********
// Behavioural oscillator and PLL macros
// ********
module cgc_osc_model (
    // Control from the block.
    input wire logic main_osc_power,
    input wire logic osc_bypass_out,
    input wire logic pll_power,
    // Clocks to the block.
    output logic slow_clock,
    output logic main_osc_clk,
    output logic pll_core_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    // The slow clock never stops; offset so it never shares an edge with ref_clk.
    initial begin
        slow_clock = 1'b0;
        #7;
        forever #100 slow_clock = ~slow_clock;
    end

    // The crystal or external source only swings while powered or bypassed.
    initial begin
        main_osc_clk = 1'b0;
        #3;
        forever #20 main_osc_clk = (main_osc_power | osc_bypass_out) & ~main_osc_clk;
    end

    // The PLL core output stays low while its power is cut.
    initial begin
        pll_core_clk = 1'b0;
        #1;
        forever #15 pll_core_clk = pll_power & ~pll_core_clk;
    end
endmodule

// ### sim/tb_top.sv
`include "cgc_consts.vh"
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, g, e); end end
// ********
// Self-checking bench
// ********
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // Counting opens on a slow rising edge and closes on the sixteenth falling one:
    // fifteen and a half slow periods of 200 ns against a 40 ns main clock.
    localparam int TALLY = 31 * 100 / 40;
    logic ref_clk, rst, slow_clock, main_osc_clk, pll_core_clk;
    logic main_osc_power, osc_bypass_out, pll_power, source_is_slow, irq;
    logic main_clock_out, pll_clock_out;
    logic [7:0] pll_div_out, s_axi_awaddr, s_axi_araddr;
    logic [10:0] pll_gain_out;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int n_fail = 0;
    int comparisons = 0;

    cgc_top i_dut (.*);
    cgc_osc_model i_osc (.*);

    // System clock.
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Write one word; a falling edge shows what the next rising edge samples.
    // No cycle count is assumed: only the watchdog ends a hung wait.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw, w, b;
        b = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge ref_clk);
            aw = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        // The response is gone once bready was sampled, and outputs have settled.
        @(negedge ref_clk);
        `CHECK(s_axi_bvalid, 1'b0)
    endtask

    // Read one word in the same manner.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar, v;
        v = 1'b0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!v) begin
            @(negedge ref_clk);
            ar = s_axi_arvalid & s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (v) s_axi_rready <= 1'b0;
        end
        @(negedge ref_clk);
        `CHECK(s_axi_rvalid, 1'b0)
    endtask

    // Cycles until the interrupt line rises, up to a limit.
    task automatic wait_irq(input int lim, output int c);
        for (c = 0; c < lim; c++) begin
            @(negedge ref_clk);
            if (irq === 1'b1) break;
        end
    endtask

    // High samples of the PLL or main clock output over forty cycles.
    task automatic count_hi(input logic pll, output int h);
        h = 0;
        repeat (40) begin
            @(negedge ref_clk);
            h += (pll ? pll_clock_out : main_clock_out) === 1'b1;
        end
    endtask

    // State straight after reset.
    task automatic t_reset;
        axi_rd(`CGC_ADDR_MOR, rd, rs);
        `CHECK(rd, 32'h0)
        axi_rd(`CGC_ADDR_PLLR, rd, rs);
        `CHECK(rd, 32'h0)
        `CHECK(main_osc_power, 1'b0)
        `CHECK(pll_clock_out, 1'b0)
    endtask

    // Refused accesses.
    task automatic t_err;
        axi_rd(8'h1C, rd, rs);
        `CHECK(rs, `CGC_RESP_SLVERR)
        `CHECK(rd, 32'h0)
        axi_wr(`CGC_ADDR_MCFR, 32'hFFFFFFFF, rs);
        `CHECK(rs, `CGC_RESP_SLVERR)
        axi_wr(8'h20, 32'h1, rs);
        `CHECK(rs, `CGC_RESP_SLVERR)
    endtask

    // Oscillator start-up, frequency count and switch-off.
    task automatic t_osc;
        int c;
        axi_wr(`CGC_ADDR_IER, 32'h1, rs);
        axi_wr(`CGC_ADDR_MOR, 32'h0201, rs);
        `CHECK(rs, `CGC_RESP_OKAY)
        axi_rd(`CGC_ADDR_SR, rd, rs);
        `CHECK(rd[0], 1'b0)
        `CHECK(main_osc_power, 1'b1)
        wait_irq(600, c);
        `CHECK(c inside {[270:330]}, 1'b1)
        axi_wr(`CGC_ADDR_IDR, 32'h1, rs);
        `CHECK(irq, 1'b0)
        axi_wr(`CGC_ADDR_IER, 32'h8, rs);
        wait_irq(500, c);
        `CHECK(c < 500, 1'b1)
        axi_rd(`CGC_ADDR_MCFR, rd, rs);
        `CHECK(rd[16], 1'b1)
        `CHECK(rd[15:0] inside {[TALLY - 2:TALLY + 2]}, 1'b1)
        // Switch off while the oscillator is still stable, so the clear is seen.
        axi_wr(`CGC_ADDR_MOR, 32'h0, rs);
        axi_rd(`CGC_ADDR_SR, rd, rs);
        `CHECK(rd[0], 1'b0)
        axi_rd(`CGC_ADDR_MCFR, rd, rs);
        `CHECK(rd[16], 1'b0)
        `CHECK(irq, 1'b0)
        `CHECK(main_osc_power, 1'b0)
        axi_wr(`CGC_ADDR_MOR, 32'hFF01, rs);
        axi_rd(`CGC_ADDR_MOR, rd, rs);
        `CHECK(rd[15:8], 8'hFF)
        axi_wr(`CGC_ADDR_MOR, 32'h0, rs);
        axi_wr(`CGC_ADDR_IDR, 32'h8, rs);
    endtask

    // Prescaler, gain and settle counting.
    task automatic t_pll;
        int c, h;
        axi_wr(`CGC_ADDR_IER, 32'h4, rs);
        axi_wr(`CGC_ADDR_PLLR, 32'h00050400, rs);
        count_hi(1'b1, h);
        `CHECK(h, 0)
        `CHECK(pll_power, 1'b1)
        wait_irq(200, c);
        axi_wr(`CGC_ADDR_PLLR, 32'h00050402, rs);
        `CHECK(irq, 1'b0)
        wait_irq(200, c);
        `CHECK(c inside {[55:105]}, 1'b1)
        `CHECK(pll_div_out, 8'h02)
        `CHECK(pll_gain_out, 11'h005)
        count_hi(1'b1, h);
        `CHECK(h inside {[1:39]}, 1'b1)
        axi_wr(`CGC_ADDR_PLLR, 32'h07FF04FF, rs);
        `CHECK(pll_gain_out, 11'h7FF)
        `CHECK(pll_div_out, 8'hFF)
        axi_rd(`CGC_ADDR_PLLR, rd, rs);
        `CHECK(rd[26:0], 27'h7FF04FF)
        axi_wr(`CGC_ADDR_PLLR, 32'h00000402, rs);
        axi_rd(`CGC_ADDR_SR, rd, rs);
        `CHECK(rd[2], 1'b0)
        `CHECK(pll_power, 1'b0)
        axi_wr(`CGC_ADDR_PLLR, 32'h00030402, rs);
        wait_irq(200, c);
        `CHECK(c inside {[55:105]}, 1'b1)
        axi_wr(`CGC_ADDR_IDR, 32'h4, rs);
    endtask

    // External clock through the bypass.
    task automatic t_bypass;
        int h;
        axi_wr(`CGC_ADDR_MOR, 32'h2, rs);
        `CHECK(osc_bypass_out, 1'b1)
        `CHECK(main_osc_power, 1'b0)
        count_hi(1'b0, h);
        `CHECK(h inside {[1:39]}, 1'b1)
        axi_wr(`CGC_ADDR_MOR, 32'h0, rs);
        count_hi(1'b0, h);
        `CHECK(h, 0)
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset, idle bus, then the scenarios in turn.
    initial begin
        rst = 1'b1;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset;
        t_err;
        t_osc;
        t_pll;
        t_bypass;
        give_verdict;
    end

    // Watchdog well beyond the thousand or so cycles the run needs.
    initial begin
        #200000;
        n_fail++;
        give_verdict;
    end
endmodule
